// [shared/dpmb_consts.svh]
`ifndef DPMB_CONSTS_SVH
`define DPMB_CONSTS_SVH

// ****************************************************************
// Clock and pin timing
// ****************************************************************
`define DPMB_CLK_PS 5000
`define DPMB_T_SETUP_NS 5
`define DPMB_T_STROBE_NS 25
`define DPMB_T_RECOVER_NS 10
`define DPMB_NS_TO_CYC(ns) (((ns) * 1000 + `DPMB_CLK_PS - 1) / `DPMB_CLK_PS)
`define DPMB_SYNC_STAGES 2
`define DPMB_CNT_W 4

// ****************************************************************
// Device layout
// ****************************************************************
`define DPMB_ADDR_W 11
`define DPMB_DATA_W 8
`define DPMB_SEM_SEL_W 3
`define DPMB_SEM_REQUEST 1'b0
`define DPMB_SEM_RELEASE 1'b1
`define DPMB_MAX_RETRY 8
`define DPMB_RETRY_W 4

`endif

// [shared/dpmb_pkg.sv]
package dpmb_pkg;

  typedef enum logic [2:0] {
    OP_MEM_RD,
    OP_MEM_WR,
    OP_MAIL_SEND,
    OP_MAIL_READ,
    OP_SEM_TAKE,
    OP_SEM_GIVE,
    OP_SEM_READ
  } dpmb_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } dpmb_state_t;

endpackage : dpmb_pkg

// [rtl/dpmb_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dpmb_consts.svh"

module dpmb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : dpmb_sync
`default_nettype wire

// [rtl/dpmb_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dpmb_consts.svh"

// What this block does
// - Select held asserted for every access
// - Semaphore select plus low address bits
// - Request by writing 0, held till 1
// - Only owner writing 1 releases
// - New read cycle to see update

module dpmb_host #(
  parameter bit IS_LEFT = 1'b1,
  parameter int ADDR_W = `DPMB_ADDR_W,
  parameter int DATA_W = `DPMB_DATA_W,
  parameter int MAX_RETRY = `DPMB_MAX_RETRY
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dpmb_pkg::dpmb_op_t cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_busy,
  output logic rsp_granted,
  output logic mail_pending,
  output logic [ADDR_W-1:0] dp_addr,
  input wire logic [DATA_W-1:0] dp_dq_i,
  output logic [DATA_W-1:0] dp_dq_o,
  output logic dp_dq_oe,
  output logic dp_ce_n,
  output logic dp_rw_n,
  output logic dp_oe_n,
  output logic sem_select_n,
  input wire logic dp_busy_n,
  input wire logic mail_irq_n
);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [`DPMB_CNT_W-1:0] SETUP_CYC = `DPMB_CNT_W'(`DPMB_NS_TO_CYC(`DPMB_T_SETUP_NS));
  // Strobe stretched to cover the input synchroniser
  localparam logic [`DPMB_CNT_W-1:0] STROBE_CYC =
    `DPMB_CNT_W'(`DPMB_NS_TO_CYC(`DPMB_T_STROBE_NS) + `DPMB_SYNC_STAGES);
  localparam logic [`DPMB_CNT_W-1:0] RECOVER_CYC =
    `DPMB_CNT_W'(`DPMB_NS_TO_CYC(`DPMB_T_RECOVER_NS));
  localparam logic [`DPMB_CNT_W-1:0] CNT_ONE = `DPMB_CNT_W'(1);
  localparam logic [`DPMB_RETRY_W-1:0] RETRY_LIM = `DPMB_RETRY_W'(MAX_RETRY);
  localparam logic [`DPMB_RETRY_W-1:0] RETRY_ONE = `DPMB_RETRY_W'(1);

  // ****************************************************************
  // Mailbox addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] TOP_ADDR = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] NEXT_ADDR = {{(ADDR_W-1){1'b1}}, 1'b0};
  // Where this port sends, and where its incoming mail sits
  localparam logic [ADDR_W-1:0] SEND_ADDR = IS_LEFT ? TOP_ADDR : NEXT_ADDR;
  localparam logic [ADDR_W-1:0] RECV_ADDR = IS_LEFT ? NEXT_ADDR : TOP_ADDR;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [DATA_W+1:0] pin_sync;

  dpmb_sync #(
    .WIDTH(DATA_W + 2),
    .RESET_VAL({2'b11, {DATA_W{1'b0}}})
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({dp_busy_n, mail_irq_n, dp_dq_i}),
    .q(pin_sync)
  );

  wire logic busy_s = ~pin_sync[DATA_W+1];
  wire logic irq_s = ~pin_sync[DATA_W];
  wire logic [DATA_W-1:0] dq_s = pin_sync[DATA_W-1:0];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  dpmb_pkg::dpmb_state_t state, next_state;
  dpmb_pkg::dpmb_op_t op, next_op;
  logic [`DPMB_CNT_W-1:0] cnt, next_cnt;
  logic [`DPMB_RETRY_W-1:0] retry, next_retry;
  logic is_wr, next_is_wr;
  logic is_sem, next_is_sem;
  logic take_rd, next_take_rd;
  logic cap_busy, next_cap_busy;
  logic [DATA_W-1:0] cap_data, next_cap_data;
  logic next_cmd_ready, next_rsp_valid, next_rsp_busy, next_rsp_granted;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic [ADDR_W-1:0] next_dp_addr;
  logic [DATA_W-1:0] next_dp_dq_o;
  logic next_dp_dq_oe, next_dp_ce_n, next_dp_rw_n, next_dp_oe_n, next_sem_select_n;

  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_retry = retry;
    next_is_wr = is_wr;
    next_is_sem = is_sem;
    next_take_rd = take_rd;
    next_cap_busy = cap_busy;
    next_cap_data = cap_data;
    next_cmd_ready = cmd_ready;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_rsp_busy = rsp_busy;
    next_rsp_granted = rsp_granted;
    next_dp_addr = dp_addr;
    next_dp_dq_o = dp_dq_o;
    next_dp_dq_oe = dp_dq_oe;
    next_dp_ce_n = dp_ce_n;
    next_dp_rw_n = dp_rw_n;
    next_dp_oe_n = dp_oe_n;
    next_sem_select_n = sem_select_n;
    unique case (state)
      dpmb_pkg::ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_op = cmd_op;
          next_cmd_ready = 1'b0;
          next_retry = '0;
          next_take_rd = 1'b0;
          next_cnt = SETUP_CYC;
          next_state = dpmb_pkg::ST_SETUP;
          next_is_sem = (cmd_op == dpmb_pkg::OP_SEM_TAKE) || (cmd_op == dpmb_pkg::OP_SEM_GIVE)
            || (cmd_op == dpmb_pkg::OP_SEM_READ);
          next_is_wr = (cmd_op == dpmb_pkg::OP_MEM_WR) || (cmd_op == dpmb_pkg::OP_MAIL_SEND)
            || (cmd_op == dpmb_pkg::OP_SEM_TAKE) || (cmd_op == dpmb_pkg::OP_SEM_GIVE);
          next_dp_dq_o = cmd_wdata;
          next_dp_addr = cmd_addr;
          unique case (cmd_op)
            dpmb_pkg::OP_MAIL_SEND: next_dp_addr = SEND_ADDR;
            dpmb_pkg::OP_MAIL_READ: next_dp_addr = RECV_ADDR;
            // Latch index on low bits; rest of address parked at zero
            dpmb_pkg::OP_SEM_TAKE: begin
              next_dp_addr = {{(ADDR_W-`DPMB_SEM_SEL_W){1'b0}}, cmd_addr[`DPMB_SEM_SEL_W-1:0]};
              next_dp_dq_o = {{(DATA_W-1){1'b0}}, `DPMB_SEM_REQUEST};
            end
            dpmb_pkg::OP_SEM_GIVE: begin
              next_dp_addr = {{(ADDR_W-`DPMB_SEM_SEL_W){1'b0}}, cmd_addr[`DPMB_SEM_SEL_W-1:0]};
              next_dp_dq_o = {{(DATA_W-1){1'b0}}, `DPMB_SEM_RELEASE};
            end
            dpmb_pkg::OP_SEM_READ: begin
              next_dp_addr = {{(ADDR_W-`DPMB_SEM_SEL_W){1'b0}}, cmd_addr[`DPMB_SEM_SEL_W-1:0]};
            end
            default: begin
            end
          endcase
        end
      end
      dpmb_pkg::ST_SETUP: begin
        next_dp_dq_oe = is_wr;
        if (cnt == CNT_ONE) begin
          // Exactly one select low: memory or semaphore cycle
          next_dp_ce_n = is_sem;
          next_sem_select_n = ~is_sem;
          next_dp_rw_n = ~is_wr;
          next_dp_oe_n = is_wr;
          next_cnt = STROBE_CYC;
          next_state = dpmb_pkg::ST_STROBE;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      dpmb_pkg::ST_STROBE: begin
        if (cnt == CNT_ONE) begin
          next_cap_data = dq_s;
          next_cap_busy = busy_s;
          next_dp_ce_n = 1'b1;
          next_sem_select_n = 1'b1;
          next_dp_rw_n = 1'b1;
          next_dp_oe_n = 1'b1;
          next_cnt = RECOVER_CYC;
          next_state = dpmb_pkg::ST_HOLD;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      dpmb_pkg::ST_HOLD: begin
        if (cnt == CNT_ONE) begin
          next_dp_dq_oe = 1'b0;
          next_cnt = SETUP_CYC;
          if (cap_busy && !is_sem && retry != RETRY_LIM &&
              (op == dpmb_pkg::OP_MAIL_SEND || op == dpmb_pkg::OP_MAIL_READ)) begin
            // Busy access was dropped by the device; repeat with select toggled
            next_retry = retry + RETRY_ONE;
            next_state = dpmb_pkg::ST_SETUP;
          end else if (op == dpmb_pkg::OP_SEM_TAKE && !take_rd) begin
            // Follow the request with a fresh read, no lockout needed
            next_take_rd = 1'b1;
            next_is_wr = 1'b0;
            next_state = dpmb_pkg::ST_SETUP;
          end else begin
            next_rsp_valid = 1'b1;
            next_rsp_rdata = cap_data;
            next_rsp_busy = cap_busy && !is_sem;
            // Zero on bit 0 means this port owns the latch
            next_rsp_granted = is_sem && !is_wr && !cap_data[0];
            next_cmd_ready = 1'b1;
            next_state = dpmb_pkg::ST_IDLE;
          end
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= dpmb_pkg::ST_IDLE;
      op <= dpmb_pkg::OP_MEM_RD;
      cnt <= '0;
      retry <= '0;
      is_wr <= 1'b0;
      is_sem <= 1'b0;
      take_rd <= 1'b0;
      cap_busy <= 1'b0;
      cap_data <= '0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_busy <= 1'b0;
      rsp_granted <= 1'b0;
      mail_pending <= 1'b0;
      dp_addr <= '0;
      dp_dq_o <= '0;
      dp_dq_oe <= 1'b0;
      dp_ce_n <= 1'b1;
      dp_rw_n <= 1'b1;
      dp_oe_n <= 1'b1;
      sem_select_n <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      retry <= next_retry;
      is_wr <= next_is_wr;
      is_sem <= next_is_sem;
      take_rd <= next_take_rd;
      cap_busy <= next_cap_busy;
      cap_data <= next_cap_data;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      rsp_busy <= next_rsp_busy;
      rsp_granted <= next_rsp_granted;
      mail_pending <= irq_s;
      dp_addr <= next_dp_addr;
      dp_dq_o <= next_dp_dq_o;
      dp_dq_oe <= next_dp_dq_oe;
      dp_ce_n <= next_dp_ce_n;
      dp_rw_n <= next_dp_rw_n;
      dp_oe_n <= next_dp_oe_n;
      sem_select_n <= next_sem_select_n;
    end
  end

endmodule : dpmb_host
`default_nettype wire

// [testbench/dpmb_host_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dpmb_host_chk #(
  parameter bit IS_LEFT = 1'b1,
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire dpmb_pkg::dpmb_op_t cmd_op,
  input wire logic rsp_busy,
  input wire logic mail_pending,
  input wire logic [ADDR_W-1:0] dp_addr,
  input wire logic [DATA_W-1:0] dp_dq_o,
  input wire logic dp_dq_oe,
  input wire logic dp_ce_n,
  input wire logic dp_rw_n,
  input wire logic dp_oe_n,
  input wire logic sem_select_n,
  input wire logic mail_irq_n
);
  localparam logic [ADDR_W-1:0] TOP = '1;
  localparam logic [ADDR_W-1:0] OUT_MB = IS_LEFT ? TOP : TOP - 1'b1;
  localparam logic [ADDR_W-1:0] IN_MB = IS_LEFT ? TOP - 1'b1 : TOP;
  logic act;
  logic acc;
  logic sem_wr;
  assign act = !dp_ce_n || !sem_select_n;
  assign acc = cmd_valid && cmd_ready;
  assign sem_wr = !sem_select_n && !dp_rw_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  idle_strobe_a: assert property ((!dp_rw_n || !dp_oe_n) |-> act)
    else $error("rw or oe low without a select");
  strobe_len_a: assert property ($rose(act) |-> act[*7] ##1 !act)
    else $error("strobe not seven cycles");
  mail_send_a: assert property (acc && cmd_op == dpmb_pkg::OP_MAIL_SEND |=> dp_addr == OUT_MB)
    else $error("mail send to wrong address");
  mail_read_a: assert property (acc && cmd_op == dpmb_pkg::OP_MAIL_READ |=> dp_addr == IN_MB)
    else $error("mail read from wrong address");
  sem_select_a: assert property (!sem_select_n |-> dp_ce_n && dp_addr[ADDR_W-1:3] == '0)
    else $error("bad semaphore select cycle");
  sem_data_a: assert property (sem_wr |-> dp_dq_o[DATA_W-1:1] == '0)
    else $error("semaphore write upper bits not zero");
  bus_drive_a: assert property ((!dp_rw_n |-> dp_dq_oe) and (!dp_oe_n |-> !dp_dq_oe))
    else $error("data bus drive does not match strobe");
  take_seq_a: assert property (acc && cmd_op == dpmb_pkg::OP_SEM_TAKE |->
    ##[2:4] (sem_wr && !dp_dq_o[0]) ##[8:12] (!sem_select_n && !dp_oe_n))
    else $error("take is not write zero then read");
  give_one_a: assert property (acc && cmd_op == dpmb_pkg::OP_SEM_GIVE |->
    ##[2:4] (sem_wr && dp_dq_o[0]))
    else $error("give did not write one");
  pend_set_a: assert property ((!mail_irq_n)[*4] |=> mail_pending)
    else $error("pending not raised");
  pend_clr_a: assert property ((mail_irq_n)[*4] |=> !mail_pending)
    else $error("pending not cleared");
  cover property (acc && cmd_op == dpmb_pkg::OP_MAIL_SEND);
  cover property (acc && cmd_op == dpmb_pkg::OP_SEM_TAKE);
  cover property (rsp_busy);
endmodule : dpmb_host_chk
bind dpmb_host dpmb_host_chk #(.IS_LEFT(IS_LEFT), .ADDR_W(ADDR_W), .DATA_W(DATA_W))
  dpmb_host_chk_inst (.clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .rsp_busy, .mail_pending,
  .dp_addr, .dp_dq_o, .dp_dq_oe, .dp_ce_n, .dp_rw_n, .dp_oe_n, .sem_select_n, .mail_irq_n);
`default_nettype wire

// [testbench/dpmb_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpmb_dev_model (
  input wire logic clk,
  input wire logic [1:0] stall,
  input wire logic [10:0] addr [2],
  input wire logic [7:0] wd [2],
  input wire logic [1:0] ce_n,
  input wire logic [1:0] rw_n,
  input wire logic [1:0] oe_n,
  input wire logic [1:0] sem_n,
  output logic [7:0] rd [2],
  output logic [1:0] busy_n,
  output var logic [1:0] irq_n
);
  logic [7:0] mem [2048];
  logic [7:0] q [2] = '{8'h00, 8'h00};
  logic [1:0] req [8] = '{default: 2'b11};
  logic [1:0] own [8] = '{default: 2'b00};
  logic [1:0] act_d = 2'b00;
  logic [1:0] act;
  int i;
  initial irq_n = 2'b11;
  assign act = ~ce_n | ~sem_n;
  assign busy_n = ~(stall & act);
  // Released lines show the inverse so stale data never looks valid
  always_comb for (int p = 0; p < 2; p++) rd[p] = (act[p] && !oe_n[p]) ? q[p] : ~q[p];
  // Left is served first in a cycle, so a tie grants one side only
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      i = int'(addr[p][2:0]);
      if (act[p] && !rw_n[p] && !sem_n[p]) begin
        req[i][p] = wd[p][0];
        if (!wd[p][0] && own[i] == 2'd0) own[i] = 2'(p + 1);
        if (wd[p][0] && own[i] == 2'(p + 1)) own[i] = req[i][1-p] ? 2'd0 : 2'(2 - p);
      end
      if (act[p] && !rw_n[p] && !ce_n[p] && !stall[p]) begin
        mem[addr[p]] = wd[p];
        if (addr[p] == 11'(11'h7FF - p)) irq_n[1-p] <= 1'b0;
      end
      if (!act_d[p] && act[p] && rw_n[p]) begin
        q[p] <= !sem_n[p] ? {8{own[i] != 2'(p + 1)}} : mem[addr[p]];
        if (!ce_n[p] && !stall[p] && addr[p] == 11'(11'h7FE + p)) irq_n[p] <= 1'b1;
      end
    end
    act_d <= act;
  end
endmodule : dpmb_dev_model
`default_nettype wire

// [testbench/tb_dpmb_host.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dpmb_host;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] stall = 2'b00;
  logic [1:0] cv = 2'b00;
  dpmb_pkg::dpmb_op_t cop [2] = '{dpmb_pkg::OP_MEM_RD, dpmb_pkg::OP_MEM_RD};
  logic [10:0] ca [2] = '{11'h000, 11'h000};
  logic [7:0] cd [2] = '{8'h00, 8'h00};
  wire [1:0] cr, rv, rb, rg, mp, oe, ce_n, rw_n, oe_n, sem_n, busy_n, irq_n;
  wire [7:0] rdat [2];
  wire [7:0] dqo [2];
  wire [7:0] dqi [2];
  wire [10:0] pa [2];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  for (genvar g = 0; g < 2; g++) begin : g_port
    dpmb_host #(.IS_LEFT(g == 0)) dpmb_host_inst (.clk(clk), .rst_b(rst_b), .cmd_valid(cv[g]),
      .cmd_ready(cr[g]), .cmd_op(cop[g]), .cmd_addr(ca[g]), .cmd_wdata(cd[g]), .rsp_valid(rv[g]),
      .rsp_rdata(rdat[g]), .rsp_busy(rb[g]), .rsp_granted(rg[g]), .mail_pending(mp[g]),
      .dp_addr(pa[g]), .dp_dq_i(dqi[g]), .dp_dq_o(dqo[g]), .dp_dq_oe(oe[g]), .dp_ce_n(ce_n[g]),
      .dp_rw_n(rw_n[g]), .dp_oe_n(oe_n[g]), .sem_select_n(sem_n[g]), .dp_busy_n(busy_n[g]),
      .mail_irq_n(irq_n[g]));
  end
  dpmb_dev_model dpmb_dev_model_inst (.clk(clk), .stall(stall), .addr(pa), .wd(dqo), .ce_n(ce_n),
    .rw_n(rw_n), .oe_n(oe_n), .sem_n(sem_n), .rd(dqi), .busy_n(busy_n), .irq_n(irq_n));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Ends four cycles after the response so the pending flag has crossed
  task automatic run(input int p, input dpmb_pkg::dpmb_op_t op, input int a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cv[p] <= 1'b1;
    cop[p] <= op;
    ca[p] <= 11'(a);
    cd[p] <= d;
    @(posedge clk);
    while (cr[p] !== 1'b1) @(posedge clk);
    cv[p] <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rv[p] !== 1'b1 && n < 400);
    if (n >= 400) error_cnt++;
    repeat (4) @(posedge clk);
  endtask : run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    run(0, dpmb_pkg::OP_MEM_WR, 'h005, 8'h5A);
    run(1, dpmb_pkg::OP_MEM_RD, 'h005, 8'h00);
    chk(rdat[1], 8'h5A);
    $display("test memory done");
    run(0, dpmb_pkg::OP_MAIL_SEND, 0, 8'hA5);
    chk(8'(mp), 8'h02);
    run(0, dpmb_pkg::OP_MEM_RD, 'h7FF, 8'h00);
    chk(rdat[0], 8'hA5);
    chk(8'(mp), 8'h02);
    run(1, dpmb_pkg::OP_MAIL_READ, 0, 8'h00);
    chk(rdat[1], 8'hA5);
    chk(8'(mp), 8'h00);
    run(1, dpmb_pkg::OP_MEM_RD, 'h7FF, 8'h00);
    chk(rdat[1], 8'hA5);
    run(1, dpmb_pkg::OP_MAIL_SEND, 0, 8'hC3);
    chk(8'(mp), 8'h01);
    stall[0] <= 1'b1;
    run(0, dpmb_pkg::OP_MAIL_READ, 0, 8'h00);
    chk(8'({rb[0], mp}), 8'h05);
    run(0, dpmb_pkg::OP_MAIL_SEND, 0, 8'h77);
    chk(8'({rb[0], mp}), 8'h05);
    stall[0] <= 1'b0;
    run(0, dpmb_pkg::OP_MAIL_READ, 0, 8'h00);
    chk(rdat[0], 8'hC3);
    chk(8'(mp), 8'h00);
    $display("test mailbox done");
    // Right keeps each semaphore, so a wrong index shows in the next round
    for (int s = 0; s < 8; s++) begin
      run(0, dpmb_pkg::OP_SEM_TAKE, s, 8'h00);
      chk(8'(rg[0]), 8'h01);
      run(1, dpmb_pkg::OP_SEM_TAKE, s, 8'h00);
      chk(8'(rg[1]), 8'h00);
      run(1, dpmb_pkg::OP_SEM_GIVE, s, 8'h00);
      run(0, dpmb_pkg::OP_SEM_READ, s, 8'h00);
      chk(rdat[0], 8'h00);
      run(1, dpmb_pkg::OP_SEM_TAKE, s, 8'h00);
      run(0, dpmb_pkg::OP_MEM_WR, s, 8'hFF);
      run(1, dpmb_pkg::OP_SEM_READ, s, 8'h00);
      chk(rdat[1], 8'hFF);
      run(0, dpmb_pkg::OP_SEM_GIVE, s, 8'h00);
      run(1, dpmb_pkg::OP_SEM_READ, s, 8'h00);
      chk(8'(rg[1]), 8'h01);
    end
    $display("test semaphores done");
    run(1, dpmb_pkg::OP_SEM_GIVE, 7, 8'h00);
    fork
      run(0, dpmb_pkg::OP_SEM_TAKE, 7, 8'h00);
      run(1, dpmb_pkg::OP_SEM_TAKE, 7, 8'h00);
    join
    chk(8'(rg[0] ^ rg[1]), 8'h01);
    $display("test contention done");
    stop_test();
  end
endmodule : tb_dpmb_host
`default_nettype wire
